// >>> design/prioritized_interrupt_acceptance.sv
/*
  Interrupt controller with the processor's acceptance sequencer:
  pending latches, per-source levels, transfer-trigger channels,
  mask, nesting count, stacking and vector fetch, plus an Avalon-MM
  slave for the level and channel registers.
  Assumes source lines arrive asynchronously from pins; instruction
  strobes, stack pointer, PC, SR and handler data come from the core
  on clk.
*/
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pia_regs.svh"

// Contract
// - Forty sources: traps, internal units, pins
// - Maskable programmable level; fixed sources level seven
// - Forward only the highest pending level
// - Accept when level at least the mask
// - Set-mask instruction loads mask, effective immediately
// - Levels 1-6; disable equals mask seven
// - Ties go to smaller vector; read clears
// - Push PC and SR at stack pointer
// - Mask becomes level plus one, seven stays
// - Acceptance increments nesting depth counter
// - Fetch handler at vector base plus vector
// - Acceptance sequence takes eighteen states
// - Return restores PC, SR; decrements nesting
// - Level 0 or 7 never accepted; here fixed level-seven sources are accepted
// - No sampling until first handler instruction
// - Reset sets mask to all ones
// - Handler table fills top 256 bytes
// - Fixed vector and transfer start code each; here fixed lines and maskable lines 35-38 have no start code
// - Illegal opcode shares trap two vector
// - Voltage detects handled at level seven
// - Transfer triggers served at level six
module prioritized_interrupt_acceptance (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`PIA_NUM_LINES-1:0] src_req,
  input wire logic illegal_opcode_interrupt,
  input wire logic set_mask_instruction,
  input wire logic [2:0] set_mask_operand,
  input wire logic disable_maskable_instruction,
  input wire logic return_from_handler_instruction,
  input wire logic [2:0] restored_sr_mask,
  input wire logic first_instr_done,
  input wire logic [23:0] cur_pc,
  input wire logic [15:0] cur_sr,
  input wire logic [23:0] system_stack_pointer,
  input wire logic [23:0] handler_data,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [2:0] interrupt_mask_level,
  output logic [7:0] nesting_depth_counter,
  output logic [7:0] accepted_vector,
  output logic push_valid,
  output logic [23:0] push_addr,
  output logic [23:0] push_data,
  output logic fetch_valid,
  output logic [23:0] fetch_addr,
  output logic branch_valid,
  output logic [23:0] branch_addr,
  output logic restore_valid,
  output logic transfer_engine_request,
  output logic [1:0] transfer_channel
);

  // Vector of each line, line 38 first
  localparam logic [`PIA_NUM_LINES-1:0][7:0] VEC = {
    8'h94, 8'h90, 8'h8C, 8'h88, 8'h84, 8'h80, 8'h7C, 8'h74, 8'h70,
    8'h68, 8'h64, 8'h60, 8'h5C, 8'h58, 8'h54, 8'h50, 8'h4C, 8'h48,
    8'h44, 8'h40, 8'h3C, 8'h38, 8'h34, 8'h30, 8'h2C, 8'h28,
    8'hA0, 8'h9C, 8'h98, 8'h24, 8'h20, 8'h1C, 8'h18, 8'h14, 8'h10,
    8'h0C, 8'h08, 8'h04, 8'h00};

  // Transfer start code of each maskable line; zero means none
  localparam logic [`PIA_NUM_MASKABLE-1:0][5:0] SCODE = {
    6'h00, 6'h00, 6'h00, 6'h00, 6'h21, 6'h20, 6'h1F, 6'h1D, 6'h1C,
    6'h1A, 6'h19, 6'h18, 6'h17, 6'h16, 6'h15, 6'h14, 6'h13, 6'h12,
    6'h11, 6'h10, 6'h0F, 6'h0E, 6'h0D, 6'h0C, 6'h0B, 6'h0A};

  pia_pkg::pia_state_s st_r;
  pia_pkg::pia_state_s st_nxt;

  pia_pkg::level_vec_t eff_lvl;
  logic [`PIA_NUM_LINES-1:0] eligible;
  logic [`PIA_NUM_LINES-1:0] is_xfer;
  logic [`PIA_NUM_LINES-1:0][1:0] xfer_ch;
  logic [`PIA_NUM_LINES-1:0] rise;
  logic win_valid;
  logic [5:0] win_idx;
  logic [2:0] win_lvl;
  logic accept;
  logic instr_now;

  // Edges are taken from the second and third flops only
  assign rise = st_r.s2[`PIA_NUM_LINES-1:0] &
    ~st_r.s3[`PIA_NUM_LINES-1:0];

  genvar g;
  generate
    for (g = 0; g < `PIA_NUM_LINES; g++) begin : g_line
      if (g < `PIA_NUM_FIXED) begin : g_fixed
        // Traps, pin, watchdog and voltage detects sit at top level
        assign eff_lvl[g] = `PIA_LEVEL_TOP;
        assign is_xfer[g] = 1'b0;
        assign xfer_ch[g] = 2'h0;
        assign eligible[g] = st_r.pend[g];
      end else begin : g_mask
        localparam int K = g - `PIA_NUM_FIXED;
        logic [3:0] hit;
        logic [1:0] ch;
        always_comb begin
          ch = 2'h0;
          for (int c = `PIA_NUM_CHAN - 1; c >= 0; c--) begin
            hit[c] = SCODE[K] != 6'h00 && st_r.chan[c] == SCODE[K];
            // Lowest channel number wins when several match
            if (hit[c]) begin
              ch = 2'(c);
            end
          end
        end
        assign is_xfer[g] = |hit;
        assign xfer_ch[g] = ch;
        assign eff_lvl[g] = is_xfer[g] ? `PIA_LEVEL_XFER :
          st_r.lvl[K];
        assign eligible[g] = st_r.pend[g] && (is_xfer[g] ||
          (st_r.lvl[K] != `PIA_LEVEL_OFF &&
           st_r.lvl[K] != `PIA_LEVEL_TOP));
      end
    end
  endgenerate

  pia_pri_select u_select (
    .req(eligible),
    .lvl(eff_lvl),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  // Acceptance only with no set-mask, disable or return strobe and no sequence open
  assign instr_now = set_mask_instruction ||
    disable_maskable_instruction || return_from_handler_instruction;
  assign accept = win_valid && win_lvl >= st_r.mask &&
    st_r.seq == pia_pkg::SEQ_IDLE && !instr_now;

  always_comb begin
    logic [2:0] widx;
    logic [4:0] bidx;
    st_nxt = st_r;
    widx = address[4:2];
    bidx = 5'h00;
    st_nxt.s1 = {illegal_opcode_interrupt, src_req};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.push_v = 1'b0;
    st_nxt.fetch_v = 1'b0;
    st_nxt.br_v = 1'b0;
    st_nxt.rest_v = 1'b0;
    st_nxt.xfer_v = 1'b0;

    // Clear on acceptance first, so a new edge below wins
    if (accept) begin
      st_nxt.pend[win_idx] = 1'b0;
    end
    st_nxt.pend = st_nxt.pend | rise;
    if (st_r.s2[`PIA_NUM_LINES] && !st_r.s3[`PIA_NUM_LINES]) begin
      st_nxt.pend[`PIA_TRAP2_LINE] = 1'b1;
    end

    if (set_mask_instruction) begin
      st_nxt.mask = set_mask_operand;
    end else if (disable_maskable_instruction) begin
      st_nxt.mask = `PIA_LEVEL_TOP;
    end else if (return_from_handler_instruction) begin
      st_nxt.mask = restored_sr_mask;
      st_nxt.nest = st_r.nest - 8'h01;
      st_nxt.rest_v = 1'b1;
    end

    case (st_r.seq)
      pia_pkg::SEQ_IDLE: begin
        if (accept && is_xfer[win_idx]) begin
          st_nxt.xfer_v = 1'b1;
          st_nxt.xfer_ch = xfer_ch[win_idx];
        end else if (accept) begin
          st_nxt.seq = pia_pkg::SEQ_RUN;
          st_nxt.cnt = 5'h01;
          st_nxt.vec = VEC[win_idx];
          st_nxt.wlvl = win_lvl;
        end
      end
      pia_pkg::SEQ_RUN: begin
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == 5'h01) begin
          st_nxt.push_v = 1'b1;
          st_nxt.push_a = system_stack_pointer - `PIA_PUSH_PC_DEC;
          st_nxt.push_d = cur_pc;
        end
        if (st_r.cnt == 5'h02) begin
          st_nxt.push_v = 1'b1;
          st_nxt.push_a = system_stack_pointer - `PIA_PUSH_SR_DEC;
          st_nxt.push_d = {8'h00, cur_sr};
        end
        if (st_r.cnt == 5'h03) begin
          st_nxt.mask = st_r.wlvl == `PIA_LEVEL_TOP ? `PIA_LEVEL_TOP :
            st_r.wlvl + 3'h1;
          st_nxt.nest = st_r.nest + 8'h01;
        end
        if (st_r.cnt == 5'(`PIA_ACK_STATES - 2)) begin
          st_nxt.fetch_v = 1'b1;
          st_nxt.fetch_a = `PIA_VEC_BASE + {16'h0000, st_r.vec};
        end
        if (st_r.cnt == 5'(`PIA_ACK_STATES - 1)) begin
          st_nxt.br_v = 1'b1;
          st_nxt.br_a = handler_data;
          st_nxt.seq = pia_pkg::SEQ_FIRST;
        end
      end
      pia_pkg::SEQ_FIRST: begin
        if (first_instr_done) begin
          st_nxt.seq = pia_pkg::SEQ_IDLE;
        end
      end
      default: begin
        st_nxt.seq = pia_pkg::SEQ_IDLE;
      end
    endcase

    // Avalon slave: one wait cycle, then a single answer cycle
    st_nxt.wait_r = 1'b1;
    if ((read || write) && st_r.wait_r) begin
      st_nxt.wait_r = 1'b0;
      st_nxt.rdata = 32'h0000_0000;
      if (widx < 3'h4) begin
        for (int j = 0; j < 8; j++) begin
          bidx = 5'({widx, 3'h0} + 5'(j));
          if (bidx < 5'(`PIA_NUM_MASKABLE)) begin
            st_nxt.rdata[4*j +: 3] = st_r.lvl[bidx];
            if (write && byteenable[j/2]) begin
              st_nxt.lvl[bidx] = writedata[4*j +: 3];
            end
          end
        end
      end else if ({widx, 2'b00} == `PIA_OFS_CHAN) begin
        for (int c = 0; c < `PIA_NUM_CHAN; c++) begin
          st_nxt.rdata[8*c +: 6] = st_r.chan[c];
          if (write && byteenable[c]) begin
            st_nxt.chan[c] = writedata[8*c +: 6];
          end
        end
      end else if ({widx, 2'b00} == `PIA_OFS_STATUS) begin
        st_nxt.rdata[`PIA_STATUS_MASK_POS +: 3] = st_r.mask;
        st_nxt.rdata[`PIA_STATUS_BUSY_POS] =
          st_r.seq != pia_pkg::SEQ_IDLE;
        st_nxt.rdata[`PIA_STATUS_NEST_POS +: 8] = st_r.nest;
      end else if ({widx, 2'b00} == `PIA_OFS_PEND_LO) begin
        st_nxt.rdata = st_r.pend[31:0];
      end else begin
        st_nxt.rdata[`PIA_NUM_LINES-33:0] =
          st_r.pend[`PIA_NUM_LINES-1:32];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.mask <= `PIA_MASK_RESET;
      st_r.lvl <= {`PIA_NUM_MASKABLE{`PIA_LEVEL_RESET}};
      st_r.seq <= pia_pkg::SEQ_IDLE;
      st_r.wait_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign readdata = st_r.rdata;
  assign waitrequest = st_r.wait_r;
  assign interrupt_mask_level = st_r.mask;
  assign nesting_depth_counter = st_r.nest;
  assign accepted_vector = st_r.vec;
  assign push_valid = st_r.push_v;
  assign push_addr = st_r.push_a;
  assign push_data = st_r.push_d;
  assign fetch_valid = st_r.fetch_v;
  assign fetch_addr = st_r.fetch_a;
  assign branch_valid = st_r.br_v;
  assign branch_addr = st_r.br_a;
  assign restore_valid = st_r.rest_v;
  assign transfer_engine_request = st_r.xfer_v;
  assign transfer_channel = st_r.xfer_ch;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic acc_int;
  assign acc_int = accept && !is_xfer[win_idx];

  a_accept_level: assert property (accept |-> win_lvl >= st_r.mask)
    else $error("accepted below mask");
  a_busy_blocks: assert property (
    st_r.seq != pia_pkg::SEQ_IDLE |=> !transfer_engine_request &&
      accepted_vector == $past(accepted_vector))
    else $error("accepted during sequence");
  a_branch_time: assert property (
    acc_int |-> ##18 branch_valid)
    else $error("branch not at eighteenth state");
  a_branch_source: assert property (
    branch_valid |-> $past(acc_int, 18))
    else $error("branch without acceptance");
  a_push_pair: assert property (
    acc_int |-> ##2 push_valid &&
      push_addr == $past(system_stack_pointer) - `PIA_PUSH_PC_DEC
      ##1 push_valid && push_data[15:0] == $past(cur_sr))
    else $error("stack pushes wrong");
  a_mask_raise: assert property (
    acc_int && !instr_now |-> ##4 interrupt_mask_level ==
      ($past(win_lvl, 4) == 3'h7 ? 3'h7 : $past(win_lvl, 4) + 3'h1))
    else $error("mask not raised");
  a_nest_count: assert property (
    acc_int |-> ##4 nesting_depth_counter ==
      $past(nesting_depth_counter, 4) + 8'h01)
    else $error("nesting not incremented");
  a_fetch_addr: assert property (
    fetch_valid |-> fetch_addr[23:8] == 16'hFFFF &&
      fetch_addr[7:0] == accepted_vector)
    else $error("vector fetch address wrong");
  a_set_mask: assert property (
    set_mask_instruction && st_r.seq == pia_pkg::SEQ_IDLE |=>
      interrupt_mask_level == $past(set_mask_operand))
    else $error("mask not loaded");
  a_disable_mask: assert property (
    disable_maskable_instruction && !set_mask_instruction &&
      st_r.seq == pia_pkg::SEQ_IDLE |=> interrupt_mask_level == 3'h7)
    else $error("disable did not block");
  a_return_nest: assert property (
    return_from_handler_instruction && !set_mask_instruction &&
      !disable_maskable_instruction && st_r.seq == pia_pkg::SEQ_IDLE
      |=> restore_valid && nesting_depth_counter ==
      $past(nesting_depth_counter) - 8'h01)
    else $error("return did not unwind");

endmodule

// >>> design/pia_regs.svh
/*
  Constants of the prioritized interrupt acceptance block: register
  offsets, field positions, reset values and sequence counts.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef PIA_REGS_SVH
`define PIA_REGS_SVH

`define PIA_NUM_LINES 39
`define PIA_NUM_FIXED 13
`define PIA_NUM_MASKABLE 26
`define PIA_TRAP2_LINE 2
`define PIA_NUM_CHAN 4

`define PIA_OFS_LEVEL0 5'h00
`define PIA_OFS_LEVEL1 5'h04
`define PIA_OFS_LEVEL2 5'h08
`define PIA_OFS_LEVEL3 5'h0C
`define PIA_OFS_CHAN 5'h10
`define PIA_OFS_STATUS 5'h14
`define PIA_OFS_PEND_LO 5'h18
`define PIA_OFS_PEND_HI 5'h1C

`define PIA_STATUS_MASK_POS 0
`define PIA_STATUS_BUSY_POS 4
`define PIA_STATUS_NEST_POS 8

`define PIA_MASK_RESET 3'h7
`define PIA_LEVEL_RESET 3'h0
`define PIA_LEVEL_TOP 3'h7
`define PIA_LEVEL_XFER 3'h6
`define PIA_LEVEL_OFF 3'h0
`define PIA_VEC_BASE 24'hFF_FF00
`define PIA_ACK_STATES 18
`define PIA_PUSH_PC_DEC 24'h00_0004
`define PIA_PUSH_SR_DEC 24'h00_0006

`endif

// >>> design/pia_pkg.sv
/*
  Types of the prioritized interrupt acceptance block.
  Assumes pia_regs.svh is on the include path.
*/
`include "pia_regs.svh"

package pia_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_FIRST = 2'b11
  } seq_e;

  typedef logic [`PIA_NUM_LINES-1:0][2:0] level_vec_t;

  typedef struct packed {
    logic [`PIA_NUM_LINES:0] s1;
    logic [`PIA_NUM_LINES:0] s2;
    logic [`PIA_NUM_LINES:0] s3;
    logic [`PIA_NUM_LINES-1:0] pend;
    logic [`PIA_NUM_MASKABLE-1:0][2:0] lvl;
    logic [`PIA_NUM_CHAN-1:0][5:0] chan;
    logic [2:0] mask;
    logic [7:0] nest;
    seq_e seq;
    logic [4:0] cnt;
    logic [2:0] wlvl;
    logic [7:0] vec;
    logic push_v;
    logic [23:0] push_a;
    logic [23:0] push_d;
    logic fetch_v;
    logic [23:0] fetch_a;
    logic br_v;
    logic [23:0] br_a;
    logic rest_v;
    logic xfer_v;
    logic [1:0] xfer_ch;
    logic wait_r;
    logic [31:0] rdata;
  } pia_state_s;

endpackage

// >>> design/pia_pri_select.sv
/*
  Picks the pending line with the highest level; equal levels go to
  the lower line index, which is also the smaller vector.
  Assumes lines are ordered by vector value within each level.
*/
`timescale 1ns/1ps
`include "pia_regs.svh"

module pia_pri_select (
  input wire logic [`PIA_NUM_LINES-1:0] req,
  input wire pia_pkg::level_vec_t lvl,
  output logic win_valid,
  output logic [5:0] win_idx,
  output logic [2:0] win_lvl
);

  always_comb begin
    win_valid = 1'b0;
    win_idx = 6'h00;
    win_lvl = 3'h0;
    for (int i = 0; i < `PIA_NUM_LINES; i++) begin
      // Strict compare keeps the earlier (smaller vector) winner
      if (req[i] && (!win_valid || lvl[i] > win_lvl)) begin
        win_valid = 1'b1;
        win_idx = 6'(i);
        win_lvl = lvl[i];
      end
    end
  end

endmodule

// >>> verif/pia_core_model.sv
/*
  Core-side model: handler table and first handler instruction.
  Assumes branch_valid pulses once per acceptance on clk.
*/
`timescale 1ns/1ps

module pia_core_model #(
  parameter int DELAY = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [23:0] fetch_addr,
  input wire logic branch_valid,
  output logic [23:0] handler_data,
  output logic first_instr_done
);
  int cnt_r;

  // Table in the top 256 bytes; entry address tracks the vector
  assign handler_data = {16'h0040, fetch_addr[7:0]};

  // First handler instruction retires a few cycles after entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 0;
      first_instr_done <= 1'h0;
    end else begin
      first_instr_done <= (cnt_r == 1);
      if (branch_valid) begin
        cnt_r <= DELAY;
      end else if (cnt_r > 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule

// >>> verif/tb_prioritized_interrupt_acceptance.sv
/*
  Self-checking bench: register access, acceptance, nesting, transfer.
  Assumes pia_regs.svh on the include path and the core model.
*/
`timescale 1ns/1ps
`include "pia_regs.svh"
`define CHK(s, e, g) begin checked++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", s, e, g); end end

module tb_prioritized_interrupt_acceptance;
  logic clk = 1'h0, rst_n = 1'h0;
  logic [`PIA_NUM_LINES-1:0] src_req = '0;
  logic ill = 1'h0, smi = 1'h0, dmi = 1'h0, rfi = 1'h0;
  logic [2:0] smo = 3'h0, rsm = 3'h0, mask;
  logic [4:0] address = 5'h00;
  logic read = 1'h0, write = 1'h0, fid, waitrequest;
  logic [31:0] writedata = 32'h0000_0000, readdata, q;
  logic [7:0] nest, vec;
  logic push_v, fetch_v, br_v, xreq, rest_v;
  logic [23:0] hd, push_a, push_d, fetch_a, br_a;
  logic [1:0] xch;
  int bad_count = 0, checked = 0, w;

  always #2.5 clk = ~clk;

  prioritized_interrupt_acceptance dut (.clk(clk), .rst_n(rst_n),
    .src_req(src_req), .illegal_opcode_interrupt(ill),
    .set_mask_instruction(smi), .set_mask_operand(smo),
    .disable_maskable_instruction(dmi),
    .return_from_handler_instruction(rfi), .restored_sr_mask(rsm),
    .first_instr_done(fid), .cur_pc(24'h12_3456), .cur_sr(16'hA5C3),
    .system_stack_pointer(24'h00_8000), .handler_data(hd),
    .address(address), .read(read), .write(write), .byteenable(4'hF),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .interrupt_mask_level(mask),
    .nesting_depth_counter(nest), .accepted_vector(vec),
    .push_valid(push_v), .push_addr(push_a), .push_data(push_d),
    .fetch_valid(fetch_v), .fetch_addr(fetch_a), .branch_valid(br_v),
    .branch_addr(br_a), .restore_valid(rest_v),
    .transfer_engine_request(xreq), .transfer_channel(xch));

  pia_core_model core (.clk(clk), .rst_n(rst_n), .fetch_addr(fetch_a),
    .branch_valid(br_v), .handler_data(hd), .first_instr_done(fid));

  task report_and_stop;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task fail_to;
    bad_count++;
    $display("[ERR] wait exp done got timeout");
    report_and_stop;
  endtask

  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    // Sampled at the edge itself, so readdata is taken where it stands
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'h0) break;
    end
    if (n == 20) fail_to;
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask

  // k: bit 0 set mask, bit 1 disable, bit 2 return
  task ins(input logic [2:0] k, input logic [2:0] v);
    @(posedge clk);
    {rfi, dmi, smi} <= k;
    smo <= v;
    rsm <= v;
    @(posedge clk);
    {rfi, dmi, smi} <= 3'h0;
    #1;
    `CHK("restore", k[2], rest_v)
    @(posedge clk);
    #1;
  endtask

  task fire(input logic [38:0] b, input logic i);
    @(posedge clk);
    src_req <= b;
    ill <= i;
    repeat (2) @(posedge clk);
    src_req <= '0;
    ill <= 1'h0;
  endtask

  task expect_irq(input logic [7:0] v, input logic [2:0] m,
                  input logic [7:0] n);
    for (w = 0; w < 60; w++) begin
      @(posedge clk);
      #1;
      if (push_v === 1'h1) break;
    end
    if (w == 60) fail_to;
    `CHK("pc addr", 24'h00_7FFC, push_a)
    `CHK("pc", 24'h12_3456, push_d)
    @(posedge clk);
    #1;
    `CHK("sr addr", 24'h00_7FFA, push_a)
    `CHK("sr", 24'h00_A5C3, push_d)
    @(posedge clk);
    #1;
    `CHK("mask", m, mask)
    `CHK("nest", n, nest)
    repeat (13) @(posedge clk);
    #1;
    `CHK("fetch", 1'h1, fetch_v)
    `CHK("fetch addr", {16'hFFFF, v}, fetch_a)
    `CHK("vector", v, vec)
    @(posedge clk);
    #1;
    `CHK("branch", 1'h1, br_v)
    `CHK("branch addr", {16'h0040, v}, br_a)
  endtask

  task quiet(input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      if (push_v === 1'h1 || xreq === 1'h1) k++;
    end
    `CHK("idle", 0, k)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    #1;
    `CHK("rst mask", 3'h7, mask)
    `CHK("rst nest", 8'h00, nest)
    bus(1'h0, 5'h14, 32'h0000_0000);
    `CHK("status", 32'h0000_0007, q)
    bus(1'h1, 5'h00, 32'h0052_7033);
    bus(1'h0, 5'h00, 32'h0000_0000);
    `CHK("level0", 32'h0052_7033, q)
    bus(1'h1, 5'h0C, 32'hFFFF_FFFF);
    bus(1'h0, 5'h0C, 32'h0000_0000);
    `CHK("level3", 32'h0000_0077, q)
    fire(39'h500, 1'h0);
    expect_irq(8'h20, 3'h7, 8'h01);
    expect_irq(8'h98, 3'h7, 8'h02);
    `CHK("held off", 1'h1, w > 8)
    ins(3'h4, 3'h7);
    `CHK("ret nest", 8'h01, nest)
    ins(3'h4, 3'h3);
    `CHK("ret mask", 3'h3, mask)
    ins(3'h1, 3'h2);
    `CHK("set mask", 3'h2, mask)
    fire(39'h1_E000, 1'h0);
    expect_irq(8'h28, 3'h4, 8'h01);
    quiet(20);
    ins(3'h4, 3'h2);
    expect_irq(8'h2C, 3'h4, 8'h01);
    ins(3'h4, 3'h2);
    quiet(20);
    fire(39'h6_0000, 1'h0);
    expect_irq(8'h3C, 3'h6, 8'h01);
    ins(3'h4, 3'h2);
    expect_irq(8'h38, 3'h3, 8'h01);
    ins(3'h4, 3'h2);
    ins(3'h2, 3'h0);
    `CHK("disabled", 3'h7, mask)
    fire(39'h4_0000, 1'h0);
    quiet(20);
    ins(3'h1, 3'h5);
    expect_irq(8'h3C, 3'h6, 8'h01);
    ins(3'h4, 3'h1);
    fire(39'h0, 1'h1);
    expect_irq(8'h08, 3'h7, 8'h01);
    ins(3'h4, 3'h1);
    bus(1'h1, 5'h10, 32'h0000_000A);
    fire(39'h2000, 1'h0);
    for (w = 0; w < 40; w++) begin
      @(posedge clk);
      #1;
      if (xreq === 1'h1) break;
    end
    if (w == 40) fail_to;
    `CHK("channel", 2'h0, xch)
    `CHK("xfer mask", 3'h1, mask)
    `CHK("xfer nest", 8'h00, nest)
    report_and_stop;
  end
endmodule
